// File: design/apbf_formatter.sv
// analog packet body formatter: descriptor words then sampling schedules
//
// What this block does
// - body opens with descriptors covering every subchannel
// - shared descriptor only when all formats match
// - top three descriptor bits always zero
// - uniform flag: 0 individual, 1 shared
// - four-bit rate exponent, rate over 2^K
// - total count equals subchannels; zero means 256
// - same total count in every descriptor
// - subchannel number field; zero means 256
// - individual descriptors ascending, 256 last
// - shared descriptor carries subchannel number zero
// - six-bit sample width, zero means 64
// - mode codes: packed, lsb pad, msb pad
// - one packing mode across the packet
// - single channel: flag/number pairs 1/0, 0/1; the check lets a lone individual entry carry any subchannel number
// - full schedule follows last descriptor
// - fastest subchannel sets primary rate
// - rate 1/2^K appears every 2^K samples
// - 2^Kmax simultaneous samples, last includes all
// - ascending subchannel order inside each sample
// - unpacked samples zero padded to a multiple of 16 bits
// - packed samples concatenated, last word msb filled
// - first-sample strobe for header time
`include "apbf_regs.svh"

module apbf_formatter
    import apbf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [`APBF_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [`APBF_IDX_W-1:0] samp_entry,
    output logic samp_ready,
    input wire logic samp_valid,
    input wire logic [63:0] samp_data,
    output logic out_valid,
    output logic [15:0] out_data,
    output logic out_first,
    output logic out_last,
    input wire logic out_ready,
    output logic first_sample,
    output logic busy
);

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] cfg [`APBF_NUM_CH];
    logic [`APBF_NUM_CH-1:0] en;
    logic [8:0] key [`APBF_NUM_CH];
    logic [3:0] fac [`APBF_NUM_CH];
    logic [7:0] sub [`APBF_NUM_CH];
    logic [5:0] len [`APBF_NUM_CH];
    logic [1:0] mode [`APBF_NUM_CH];
    logic ctrl_hit;
    logic go;

    assign ctrl_hit = reg_wr && (reg_addr == `APBF_ADDR_CTRL);
    assign go = ctrl_hit && reg_wdata[`APBF_CTRL_GO];

    // settings are frozen while a packet is being built
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl <= `APBF_CTRL_RST;
        end else if (ctrl_hit && !busy) begin
            ctrl <= reg_wdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `APBF_NUM_CH; gi++) begin : g_ent
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    cfg[gi] <= `APBF_CFG_RST;
                end else if (reg_wr && !busy && reg_addr[7:5] == `APBF_CFG_PAGE
                             && reg_addr[4:2] == `APBF_IDX_W'(gi)) begin
                    cfg[gi] <= reg_wdata;
                end
            end
            assign en[gi] = cfg[gi][`APBF_CFG_EN];
            assign fac[gi] = cfg[gi][`APBF_FAC_HI:`APBF_FAC_LO];
            assign sub[gi] = cfg[gi][`APBF_SUB_HI:`APBF_SUB_LO];
            assign len[gi] = cfg[gi][`APBF_LEN_HI:`APBF_LEN_LO];
            assign mode[gi] = cfg[gi][`APBF_MODE_HI:`APBF_MODE_LO];
            // number zero stands for 256 and sorts after every other number
            assign key[gi] = {sub[gi] == `APBF_SUB_LAST, sub[gi]};
        end
    endgenerate

    // ------------------------------------------------------------------------
    // configuration check
    // ------------------------------------------------------------------------
    logic eff_uni;
    logic [7:0] cnt;
    logic [3:0] kmax;
    logic [`APBF_IDX_W-1:0] first_idx;
    logic [`APBF_IDX_W-1:0] last_idx;
    logic order_ok;
    logic mode_ok;
    logic same_ok;
    logic rsvd_hit;
    logic cfg_err;

    assign eff_uni = ctrl_hit ? reg_wdata[`APBF_CTRL_UNI] : ctrl[`APBF_CTRL_UNI];

    always_comb begin
        logic seen;
        seen = 1'b0;
        cnt = 8'h00;
        kmax = 4'h0;
        first_idx = '0;
        last_idx = '0;
        order_ok = 1'b1;
        mode_ok = 1'b1;
        same_ok = 1'b1;
        rsvd_hit = 1'b0;
        for (int i = 0; i < `APBF_NUM_CH; i++) begin
            if (en[i]) begin
                cnt = cnt + 8'h01;
                last_idx = `APBF_IDX_W'(i);
                if (!seen) begin
                    first_idx = `APBF_IDX_W'(i);
                end
                seen = 1'b1;
                if (fac[i] > kmax) begin
                    kmax = fac[i];
                end
                if (mode[i] == apbf_rsvd) begin
                    rsvd_hit = 1'b1;
                end
                if (mode[i] != mode[first_idx]) begin
                    mode_ok = 1'b0;
                end
                if (fac[i] != fac[first_idx] || len[i] != len[first_idx]) begin
                    same_ok = 1'b0;
                end
                for (int j = i + 1; j < `APBF_NUM_CH; j++) begin
                    if (en[j] && key[j] <= key[i]) begin
                        order_ok = 1'b0;
                    end
                end
            end
        end
        cfg_err = !seen || !order_ok || !mode_ok || rsvd_hit || (eff_uni && !same_ok);
    end

    // ------------------------------------------------------------------------
    // run state latched at start
    // ------------------------------------------------------------------------
    apbf_state_type state;
    apbf_state_type next_state;
    logic accept;
    logic refused;
    logic uni;
    logic [7:0] tot;
    logic [3:0] run_kmax;
    logic [7:0] sched_left;

    assign accept = go && state == apbf_idle && !cfg_err;
    assign busy = state != apbf_idle;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            uni <= 1'b0;
            tot <= 8'h00;
            run_kmax <= 4'h0;
        end else if (accept) begin
            uni <= eff_uni;
            // eight bits wrap 256 to zero
            tot <= cnt;
            run_kmax <= kmax;
        end
    end

    // a refused start leaves a sticky flag; the next accepted start clears it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            refused <= 1'b0;
        end else if (go && !accept) begin
            refused <= 1'b1;
        end else if (accept) begin
            refused <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // descriptor word and schedule position
    // ------------------------------------------------------------------------
    logic [`APBF_IDX_W-1:0] ent;
    logic [`APBF_SIM_W-1:0] sim;
    logic done;
    logic [`APBF_IDX_W-1:0] desc_idx;
    logic [31:0] desc;
    logic [`APBF_SIM_W-1:0] sim_one;
    logic [`APBF_SIM_W-1:0] ent_mask;
    logic [`APBF_SIM_W-1:0] sim_last;
    logic sel;

    assign desc_idx = uni ? first_idx : ent;
    assign desc = {{`APBF_RSVD_W{1'b0}},
                   uni,
                   fac[desc_idx],
                   tot,
                   uni ? `APBF_SUB_LAST : sub[desc_idx],
                   len[desc_idx],
                   mode[desc_idx]};

    assign sim_one = sim + `APBF_SIM_W'(1);
    assign ent_mask = (`APBF_SIM_W'(1) << fac[ent]) - `APBF_SIM_W'(1);
    assign sim_last = (`APBF_SIM_W'(1) << run_kmax) - `APBF_SIM_W'(1);
    // every 2^K-th simultaneous sample, counting from one, so the last holds all
    assign sel = en[ent] && ((sim_one & ent_mask) == '0);

    // ------------------------------------------------------------------------
    // sample slot shaping
    // ------------------------------------------------------------------------
    logic [`APBF_ACC_W-1:0] acc;
    logic [`APBF_BITS_W-1:0] acc_bits;
    logic [`APBF_BITS_W-1:0] width;
    logic [`APBF_BITS_W-1:0] slot_w;
    logic [`APBF_BITS_W-1:0] pad;
    logic [63:0] masked;
    logic [`APBF_ACC_W-1:0] slot;
    logic out_free;

    assign width = (len[ent] == 6'h00) ? `APBF_FULL_LEN : {1'b0, len[ent]};
    assign masked = samp_data & (64'hFFFF_FFFF_FFFF_FFFF >> (`APBF_FULL_LEN - width));
    assign slot_w = (mode[ent] == apbf_packed) ? width
                  : ((width + `APBF_SLICE_ROUND) & ~`APBF_SLICE_ROUND);
    assign pad = slot_w - width;
    // lsb padding puts the sample at the top of its slot; pads stay zero
    assign slot = (mode[ent] == apbf_lsbpad) ? ({16'h0000, masked} << pad)
                : {16'h0000, masked};
    assign out_free = !out_valid || out_ready;
    assign samp_entry = ent;
    assign samp_ready = state == apbf_samp && !done && acc_bits < `APBF_SLICE && sel;

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    logic [`APBF_IDX_W-1:0] next_ent;
    logic [`APBF_SIM_W-1:0] next_sim;
    logic [7:0] next_sched;
    logic next_done;
    logic [`APBF_ACC_W-1:0] next_acc;
    logic [`APBF_BITS_W-1:0] next_bits;
    logic emit;
    logic [15:0] emit_data;
    logic emit_first;
    logic emit_last;
    logic take;

    always_comb begin
        logic step;
        step = 1'b0;
        next_state = state;
        next_ent = ent;
        next_sim = sim;
        next_sched = sched_left;
        next_done = done;
        next_acc = acc;
        next_bits = acc_bits;
        emit = 1'b0;
        emit_data = 16'h0000;
        emit_first = 1'b0;
        emit_last = 1'b0;
        take = 1'b0;
        case (state)
            apbf_idle: begin
                if (accept) begin
                    next_state = apbf_desc_lo;
                    next_ent = first_idx;
                    next_sim = '0;
                    next_sched = reg_wdata[`APBF_CTRL_SCH_HI:`APBF_CTRL_SCH_LO];
                    next_done = 1'b0;
                    next_acc = '0;
                    next_bits = '0;
                end
            end
            apbf_desc_lo: begin
                if (!uni && !en[ent]) begin
                    next_ent = ent + `APBF_IDX_W'(1);
                end else if (out_free) begin
                    emit = 1'b1;
                    emit_data = desc[15:0];
                    emit_first = (uni || ent == first_idx);
                    next_state = apbf_desc_hi;
                end
            end
            apbf_desc_hi: begin
                if (out_free) begin
                    emit = 1'b1;
                    emit_data = desc[31:16];
                    if (uni || ent == last_idx) begin
                        next_state = apbf_samp;
                        next_ent = '0;
                    end else begin
                        next_state = apbf_desc_lo;
                        next_ent = ent + `APBF_IDX_W'(1);
                    end
                end
            end
            apbf_samp: begin
                if (done) begin
                    next_state = apbf_flush;
                end else if (acc_bits >= `APBF_SLICE) begin
                    if (out_free) begin
                        emit = 1'b1;
                        emit_data = acc[15:0];
                        next_acc = acc >> `APBF_SLICE;
                        next_bits = acc_bits - `APBF_SLICE;
                    end
                end else if (!sel) begin
                    step = 1'b1;
                end else if (samp_valid) begin
                    take = 1'b1;
                    step = 1'b1;
                    next_acc = acc | (slot << acc_bits);
                    next_bits = acc_bits + slot_w;
                end
                if (step) begin
                    if (ent == last_idx) begin
                        next_ent = '0;
                        if (sim == sim_last) begin
                            next_sim = '0;
                            if (sched_left == 8'h00) begin
                                next_done = 1'b1;
                            end else begin
                                next_sched = sched_left - 8'h01;
                            end
                        end else begin
                            next_sim = sim_one;
                        end
                    end else begin
                        next_ent = ent + `APBF_IDX_W'(1);
                    end
                end
            end
            apbf_flush: begin
                if (acc_bits == '0) begin
                    next_state = apbf_idle;
                end else if (out_free) begin
                    emit = 1'b1;
                    // bits above the fill level are zero: msb filler of the last word
                    emit_data = acc[15:0];
                    emit_last = acc_bits <= `APBF_SLICE;
                    next_acc = acc >> `APBF_SLICE;
                    next_bits = (acc_bits <= `APBF_SLICE) ? '0 : acc_bits - `APBF_SLICE;
                    if (acc_bits <= `APBF_SLICE) begin
                        next_state = apbf_idle;
                    end
                end
            end
            default: begin
                next_state = apbf_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= apbf_idle;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ent <= '0;
            sim <= '0;
            sched_left <= 8'h00;
            done <= 1'b0;
        end else begin
            ent <= next_ent;
            sim <= next_sim;
            sched_left <= next_sched;
            done <= next_done;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            acc <= '0;
            acc_bits <= '0;
        end else begin
            acc <= next_acc;
            acc_bits <= next_bits;
        end
    end

    // ------------------------------------------------------------------------
    // output word register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_data <= 16'h0000;
            out_first <= 1'b0;
            out_last <= 1'b0;
        end else if (emit) begin
            out_valid <= 1'b1;
            out_data <= emit_data;
            out_first <= emit_first;
            out_last <= emit_last;
        end else if (out_ready) begin
            out_valid <= 1'b0;
            out_first <= 1'b0;
            out_last <= 1'b0;
        end
    end

    // pulse on the first sample taken, so the assembler can stamp header time
    logic got_first;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            got_first <= 1'b0;
            first_sample <= 1'b0;
        end else begin
            first_sample <= take && !got_first;
            if (accept) begin
                got_first <= 1'b0;
            end else if (take) begin
                got_first <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `APBF_ADDR_CTRL) begin
                reg_rdata <= ctrl & ~(32'h0000_0001 << `APBF_CTRL_GO);
            end else if (reg_addr == `APBF_ADDR_STAT) begin
                reg_rdata <= 32'h0000_0000;
                reg_rdata[`APBF_STAT_BUSY] <= busy;
                reg_rdata[`APBF_STAT_ERR] <= cfg_err;
                reg_rdata[`APBF_STAT_REFUSED] <= refused;
                reg_rdata[`APBF_STAT_CNT_HI:`APBF_STAT_CNT_LO] <= cnt;
            end else if (reg_addr[7:5] == `APBF_CFG_PAGE && reg_addr[1:0] == 2'h0) begin
                reg_rdata <= cfg[reg_addr[4:2]];
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // apbf_formatter

// File: design/apbf_regs.svh
// register offsets, field positions and codes of the analog packet body formatter
`ifndef APBF_REGS_SVH
`define APBF_REGS_SVH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define APBF_NUM_CH 8
`define APBF_IDX_W 3
`define APBF_ADDR_W 8
`define APBF_ACC_W 80
`define APBF_BITS_W 7
`define APBF_SIM_W 16
`define APBF_SLICE 7'h10
`define APBF_FULL_LEN 7'h40
`define APBF_SLICE_ROUND 7'h0F

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define APBF_ADDR_CTRL 8'h00
`define APBF_ADDR_STAT 8'h04
`define APBF_CFG_PAGE 3'h1
`define APBF_CTRL_RST 32'h0000_0000
`define APBF_CFG_RST 32'h0000_0000

// control register fields
`define APBF_CTRL_UNI 0
`define APBF_CTRL_GO 1
`define APBF_CTRL_SCH_HI 15
`define APBF_CTRL_SCH_LO 8

// status register fields
`define APBF_STAT_BUSY 0
`define APBF_STAT_ERR 1
`define APBF_STAT_REFUSED 2
`define APBF_STAT_CNT_HI 23
`define APBF_STAT_CNT_LO 16

// ----------------------------------------------------------------------------
// descriptor word fields (entry config registers share positions 27..0)
// ----------------------------------------------------------------------------
`define APBF_CFG_EN 31
`define APBF_RSVD_W 3
`define APBF_SAME_BIT 28
`define APBF_FAC_HI 27
`define APBF_FAC_LO 24
`define APBF_TOT_HI 23
`define APBF_TOT_LO 16
`define APBF_SUB_HI 15
`define APBF_SUB_LO 8
`define APBF_LEN_HI 7
`define APBF_LEN_LO 2
`define APBF_MODE_HI 1
`define APBF_MODE_LO 0
`define APBF_SUB_LAST 8'h00

`endif

// File: design/apbf_pkg.sv
// types shared by the analog packet body formatter
package apbf_pkg;

    // ------------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        apbf_idle    = 3'b000,
        apbf_desc_lo = 3'b001,
        apbf_desc_hi = 3'b010,
        apbf_samp    = 3'b011,
        apbf_flush   = 3'b100
    } apbf_state_type;

    // ------------------------------------------------------------------------
    // packing modes
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        apbf_packed = 2'b00,
        apbf_lsbpad = 2'b01,
        apbf_rsvd   = 2'b10,
        apbf_msbpad = 2'b11
    } apbf_mode_type;

endpackage

// File: tb/apbf_checker_sva.sv
// port assertions of the analog packet body formatter
`include "apbf_regs.svh"

module apbf_checker
    import apbf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [`APBF_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [`APBF_IDX_W-1:0] samp_entry,
    input wire logic samp_ready,
    input wire logic samp_valid,
    input wire logic [63:0] samp_data,
    input wire logic out_valid,
    input wire logic [15:0] out_data,
    input wire logic out_first,
    input wire logic out_last,
    input wire logic out_ready,
    input wire logic first_sample,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic hi_next;
    // high half of the first descriptor follows its accepted low half
    always_ff @(posedge sys_clk) begin
        if (srst) hi_next <= 1'h0;
        else if (out_valid && out_ready) hi_next <= out_first;
    end
    property p_open; $rose(busy) |-> ##[1:4] (out_valid && out_first); endproperty
    a_open: assert property (p_open) else $error("body did not open with a descriptor");
    property p_mode; out_valid && out_first |-> out_data[1:0] != 2'h2; endproperty
    a_mode: assert property (p_mode) else $error("reserved packing code emitted");
    property p_rsvd; out_valid && hi_next |-> out_data[15:13] == 3'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved descriptor bits set");
    property p_stand;
        out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last);
    endproperty
    a_stand: assert property (p_stand) else $error("body word changed before acceptance");
    property p_pulse; first_sample |=> !first_sample; endproperty
    a_pulse: assert property (p_pulse)
        else $error("first sample mark longer than one cycle");
    property p_stamp; first_sample |-> $past(samp_ready && samp_valid); endproperty
    a_stamp: assert property (p_stamp)
        else $error("first sample mark without a taken sample");
    property p_take; samp_ready |-> busy; endproperty
    a_take: assert property (p_take) else $error("sample requested while idle");
    property p_end; out_valid && out_ready && out_last |=> !out_valid; endproperty
    a_end: assert property (p_end) else $error("word after the final body word");
    property p_hold; samp_ready && !samp_valid |=> $stable(samp_entry); endproperty
    a_hold: assert property (p_hold) else $error("sample entry moved before it was taken");
endmodule // apbf_checker

// File: tb/apbf_partner.sv
// front end and assembler model of the formatter
`include "apbf_regs.svh"

module apbf_partner
    import apbf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic [`APBF_IDX_W-1:0] samp_entry,
    input wire logic samp_ready,
    output logic samp_valid,
    output logic [63:0] samp_data,
    output logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ph;
    logic [7:0] cnt;
    logic [63:0] pat;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ph <= 1'h0;
            cnt <= 8'h00;
        end else begin
            ph <= ~ph;
            if (samp_ready && samp_valid) cnt <= cnt + 8'h01;
        end
    end
    // upper bits set so a missing width mask shows in the body
    assign pat = {52'hF_FFFF_FFFF_FFFF, 1'h1, cnt, samp_entry};
    assign samp_valid = !slow || ph;
    assign samp_data = samp_valid ? pat : ~pat;
    assign out_ready = !slow || !ph;
endmodule // apbf_partner

// File: tb/analog_packet_body_formatter_bench.sv
// self-checking bench of the analog packet body formatter
`include "apbf_regs.svh"

module analog_packet_body_formatter_bench
    import apbf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic uni; logic [31:0] c0; logic [31:0] c1; logic err;} apbf_row_type;
    logic sys_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, slow = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [2:0] samp_entry;
    logic samp_ready, samp_valid, out_valid, out_first, out_last, out_ready, first_sample, busy;
    logic [63:0] samp_data;
    logic [15:0] out_data;
    logic [11:0] s0, s1;
    logic [17:0] got[$];
    logic [15:0] exp[$];
    int fail_count = 0, checks_done = 0;
    apbf_row_type rows [8] = '{
        '{1'h0, 32'h8000_0133, 32'h8000_0233, 1'h0}, '{1'h0, 32'h8000_0133, 32'h8000_0133, 1'h1},
        '{1'h0, 32'h8000_0033, 32'h8000_0233, 1'h1}, '{1'h0, 32'h8000_0133, 32'h8000_0231, 1'h1},
        '{1'h0, 32'h8000_0132, 32'h8000_0232, 1'h1}, '{1'h1, 32'h8000_0133, 32'h8100_0233, 1'h1},
        '{1'h1, 32'h8000_0133, 32'h8000_0233, 1'h0}, '{1'h0, 32'h0000_0133, 32'h0000_0233, 1'h1}};

    apbf_formatter dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .samp_entry(samp_entry), .samp_ready(samp_ready), .samp_valid(samp_valid),
        .samp_data(samp_data), .out_valid(out_valid), .out_data(out_data),
        .out_first(out_first), .out_last(out_last), .out_ready(out_ready),
        .first_sample(first_sample), .busy(busy));
    apbf_partner partner (.sys_clk(sys_clk), .srst(srst), .slow(slow),
        .samp_entry(samp_entry), .samp_ready(samp_ready), .samp_valid(samp_valid),
        .samp_data(samp_data), .out_ready(out_ready));

    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (out_valid === 1'h1 && out_ready === 1'h1) got.push_back({out_last, out_first, out_data});
    end

    // ------------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------------
    task chk(input string name, input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    function logic [11:0] pat(input logic [7:0] c, input logic [2:0] e);
        return {1'h1, c, e};
    endfunction
    // waits for the final word with a bound; a hung body shows as a length mismatch
    task body(input string name);
        int i;
        i = 0;
        while (!(got.size() > 0 && got[$][17] === 1'h1) && i < 600) begin
            @(posedge sys_clk);
            i++;
        end
        chk({name, " length"}, got.size(), exp.size());
        foreach (exp[k]) if (k < got.size()) chk(name, got[k][15:0], exp[k]);
        if (got.size() > 0) chk({name, " first"}, got[0][16], 1'h1);
        got.delete();
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'h0;
        chk("busy after reset", busy, 1'h0);
        rd(8'h20);
        chk("entry reset", d, 32'h0);
        rd(8'h10);
        chk("unmapped read", d, 32'h0);
        foreach (rows[r]) begin
            wr(8'h20, rows[r].c0);
            wr(8'h24, rows[r].c1);
            wr(8'h00, {31'h0, rows[r].uni});
            rd(8'h04);
            chk("config error", d[1], rows[r].err);
            chk("enabled count", d[23:16], rows[r].c0[31] + rows[r].c1[31]);
        end
        wr(8'h00, 32'h0000_0002);
        rd(8'h04);
        chk("refused start", d[2:0], 3'h6);
        // two entries, slow partner on both sides, subchannel 256 last
        slow <= 1'h1;
        wr(8'h20, 32'h8100_0133);
        wr(8'h24, 32'h8000_0033);
        wr(8'h00, 32'h0000_0002);
        rd(8'h04);
        chk("started", d[2:0], 3'h1);
        exp = '{16'h0133, 16'h0102, 16'h0033, 16'h0002, {4'h0, pat(8'h00, 3'h1)},
            {4'h0, pat(8'h01, 3'h0)}, {4'h0, pat(8'h02, 3'h1)}};
        body("individual body");
        srst <= 1'h1;
        @(posedge sys_clk);
        srst <= 1'h0;
        slow <= 1'h0;
        wr(8'h20, 32'h8000_0530);
        wr(8'h00, 32'h0000_0103);
        s0 = pat(8'h00, 3'h0);
        s1 = pat(8'h01, 3'h0);
        exp = '{16'h0030, 16'h1001, {s1[3:0], s0}, {8'h00, s1[11:4]}};
        body("shared body");
        wr(8'h20, 32'h8000_0131);
        wr(8'h00, 32'h0000_0002);
        exp = '{16'h0131, 16'h0001, {pat(8'h02, 3'h0), 4'h0}};
        body("lsb padded body");
        stop_test();
    end
    initial begin
        #200us;
        fail_count++;
        stop_test();
    end
endmodule // analog_packet_body_formatter_bench

bind apbf_formatter apbf_checker chk_i (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .samp_entry(samp_entry), .samp_ready(samp_ready), .samp_valid(samp_valid),
    .samp_data(samp_data), .out_valid(out_valid), .out_data(out_data), .out_first(out_first),
    .out_last(out_last), .out_ready(out_ready), .first_sample(first_sample), .busy(busy));
